// ### verilog/flash_protect_pkg.sv
// Purpose: constants for the flash block-protection gate
// Assumes: 16-bit flash address space, 8-bit protect byte
// Notes: register offsets are AHB byte addresses within the block window
package flash_protect_pkg;
    // ahb register map
    localparam logic [7:0] ctrl_ofs = 8'h00;
    localparam logic [7:0] target_ofs = 8'h04;
    localparam logic [7:0] protect_byte_ofs = 8'h08;
    localparam logic [7:0] status_ofs = 8'h0c;
    localparam logic [7:0] flash_write_ofs = 8'h10;
    // control register fields
    localparam int program_select_pos = 0;
    localparam int erase_select_pos = 1;
    localparam int high_voltage_enable_pos = 3;
    localparam int block_size_low_pos = 4;
    localparam int block_size_high_pos = 5;
    localparam logic [7:0] ctrl_reset = 8'h00;
    // protect byte location and stored reset value (erased)
    localparam logic [15:0] protect_byte_addr = 16'hfff0;
    localparam logic [7:0] protect_erased = 8'h00;
    localparam logic [7:0] protect_reset = 8'h00;
    // address ranges
    localparam logic [15:0] array_start = 16'h7800;
    localparam logic [15:0] array_end = 16'h7fef;
    localparam logic [15:0] vector_start = 16'hfff0;
    localparam logic [15:0] vector_end = 16'hffff;
    localparam logic [15:0] bit3_start = 16'h7a00;
    localparam logic [15:0] bit2_start = 16'h7900;
    localparam logic [15:0] bit1_start = 16'h7880;
    localparam logic [15:0] bit0_start = 16'h7800;
    // erase block masks: full, half, eight rows, one row
    localparam logic [15:0] mask_full = 16'hf800;
    localparam logic [15:0] mask_half = 16'hfc00;
    localparam logic [15:0] mask_rows = 16'hffc0;
    localparam logic [15:0] mask_row = 16'hfff8;
endpackage : flash_protect_pkg

// ### verilog/protect_range_check.sv
// Purpose: decide whether an address span touches a protected block
// Assumes: span given as first and last address, inclusive
// Notes: pure combinational
`timescale 1ns/100ps
module protect_range_check (
    input wire logic [7:0] protect_value,
    input wire logic [15:0] span_first,
    input wire logic [15:0] span_last,
    output logic hit
);
    logic [15:0] low_start;
    logic any_set;

    always_comb begin
        // lowest set bit's start bounds the union of locked ranges
        any_set = (protect_value[3:0] != 4'h0);
        low_start = flash_protect_pkg::bit3_start;
        if (protect_value[2]) begin
            low_start = flash_protect_pkg::bit2_start;
        end
        if (protect_value[1]) begin
            low_start = flash_protect_pkg::bit1_start;
        end
        if (protect_value[0]) begin
            low_start = flash_protect_pkg::bit0_start;
        end
        hit = any_set && (
            ((span_first <= flash_protect_pkg::array_end) && (span_last >= low_start)) ||
            (span_last >= flash_protect_pkg::vector_start));
    end
endmodule : protect_range_check

// ### verilog/erase_span.sv
// Purpose: turn a latched target address into the span an operation touches
// Assumes: block size bits as in the control register
// Notes: program always touches a single byte
`timescale 1ns/100ps
module erase_span (
    input wire logic [15:0] target,
    input wire logic erase_mode,
    input wire logic [1:0] block_size,
    output logic [15:0] span_first,
    output logic [15:0] span_last
);
    logic [15:0] mask;

    always_comb begin
        case (block_size)
            2'b00: mask = flash_protect_pkg::mask_full;
            2'b01: mask = flash_protect_pkg::mask_half;
            2'b10: mask = flash_protect_pkg::mask_rows;
            default: mask = flash_protect_pkg::mask_row;
        endcase
        if (erase_mode) begin
            span_first = target & mask;
            span_last = (target & mask) | ~mask;
        end else begin
            span_first = target;
            span_last = target;
        end
    end
endmodule : erase_span

// ### verilog/flash_block_protect_gate.sv
// Purpose: block-protection gate for the on-chip flash control register
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes: protect byte contents come from the flash array as an input
//
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/100ps
module flash_block_protect_gate (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [7:0] flash_block_protect_byte,
    input wire logic elevated_pin_voltage,
    output logic high_voltage_enable,
    output logic program_select,
    output logic erase_select,
    output logic [15:0] target_addr,
    output logic protect_blocked
);
    ////////////////////////////////////////////////////////////////////////
    // bus address phase capture
    logic wr_pend_q;
    logic rd_pend_q;
    logic [7:0] addr_q;
    logic access;

    assign access = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_pend_q <= access && hwrite;
            rd_pend_q <= access && !hwrite;
            if (access) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    function automatic logic hits(input logic [7:0] a, input logic [7:0] ofs);
        hits = (a[7:2] == ofs[7:2]);
    endfunction : hits

    logic wr_ctrl;
    logic wr_flash;
    logic rd_protect;
    assign wr_ctrl = wr_pend_q && hits(addr_q, flash_protect_pkg::ctrl_ofs);
    assign wr_flash = wr_pend_q && hits(addr_q, flash_protect_pkg::flash_write_ofs);
    assign rd_protect = rd_pend_q && hits(addr_q, flash_protect_pkg::protect_byte_ofs);

    ////////////////////////////////////////////////////////////////////////
    // protect latch: captured whenever the protect byte is read
    logic [7:0] protect_latch_q;
    logic latch_valid_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            protect_latch_q <= flash_protect_pkg::protect_reset;
            latch_valid_q <= 1'b0;
        end else if (rd_protect) begin
            protect_latch_q <= flash_block_protect_byte;
            latch_valid_q <= 1'b1;
        end else if (wr_ctrl && !hwdata[flash_protect_pkg::program_select_pos]
                     && !hwdata[flash_protect_pkg::erase_select_pos]) begin
            // a fresh selection needs a fresh protect read
            latch_valid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // target address latched by the program or erase write
    logic [15:0] target_q;
    logic target_valid_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            target_q <= 16'h0000;
            target_valid_q <= 1'b0;
        end else if (wr_flash && (program_select || erase_select)) begin
            target_q <= hwdata[15:0];
            target_valid_q <= 1'b1;
        end else if (!program_select && !erase_select) begin
            target_valid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // protection comparison
    logic [15:0] span_first;
    logic [15:0] span_last;
    logic hit;
    logic [1:0] block_size_q;

    erase_span u_span (
        .target(target_q),
        .erase_mode(erase_select),
        .block_size(block_size_q),
        .span_first(span_first),
        .span_last(span_last)
    );

    protect_range_check u_check (
        .protect_value(protect_latch_q),
        .span_first(span_first),
        .span_last(span_last),
        .hit(hit)
    );

    // the protect byte itself stays locked even when every protect bit is erased
    logic covers_pb;
    assign covers_pb = (span_first <= flash_protect_pkg::protect_byte_addr) &&
                       (span_last >= flash_protect_pkg::protect_byte_addr);

    logic blocked;
    assign blocked = target_valid_q && latch_valid_q && (hit || covers_pb) &&
                     !elevated_pin_voltage;

    ////////////////////////////////////////////////////////////////////////
    // control register
    logic pgm_q;
    logic ers_q;
    logic hv_q;
    logic blocked_q;
    logic want_pgm;
    logic want_ers;
    logic want_hv;

    assign want_pgm = hwdata[flash_protect_pkg::program_select_pos];
    assign want_ers = hwdata[flash_protect_pkg::erase_select_pos];
    assign want_hv = hwdata[flash_protect_pkg::high_voltage_enable_pos];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pgm_q <= 1'b0;
            ers_q <= 1'b0;
        end else if (blocked) begin
            pgm_q <= 1'b0;
            ers_q <= 1'b0;
        end else if (wr_ctrl) begin
            // program and erase select are interlocked
            pgm_q <= want_pgm && !want_ers;
            ers_q <= want_ers && !want_pgm;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            block_size_q <= 2'b00;
        end else if (wr_ctrl) begin
            block_size_q <= {hwdata[flash_protect_pkg::block_size_high_pos],
                             hwdata[flash_protect_pkg::block_size_low_pos]};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hv_q <= 1'b0;
        end else if (blocked) begin
            hv_q <= 1'b0;
        end else if (wr_ctrl) begin
            // the same write must keep the selection that was armed
            hv_q <= want_hv && latch_valid_q && target_valid_q &&
                    ((pgm_q && want_pgm && !want_ers) || (ers_q && want_ers && !want_pgm));
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blocked_q <= 1'b0;
        end else if (blocked) begin
            blocked_q <= 1'b1;
        end else if (wr_ctrl) begin
            blocked_q <= 1'b0;
        end
    end

    assign program_select = pgm_q;
    assign erase_select = ers_q;
    assign high_voltage_enable = hv_q;
    assign target_addr = target_q;
    assign protect_blocked = blocked_q;

    ////////////////////////////////////////////////////////////////////////
    // read data
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (access && !hwrite) begin
            case (haddr[7:2])
                flash_protect_pkg::ctrl_ofs[7:2]: begin
                    rdata_d[flash_protect_pkg::program_select_pos] = pgm_q;
                    rdata_d[flash_protect_pkg::erase_select_pos] = ers_q;
                    rdata_d[flash_protect_pkg::high_voltage_enable_pos] = hv_q;
                    rdata_d[flash_protect_pkg::block_size_low_pos] = block_size_q[0];
                    rdata_d[flash_protect_pkg::block_size_high_pos] = block_size_q[1];
                end
                flash_protect_pkg::target_ofs[7:2]: rdata_d[15:0] = target_q;
                flash_protect_pkg::protect_byte_ofs[7:2]: begin
                    rdata_d[7:0] = flash_block_protect_byte;
                end
                flash_protect_pkg::status_ofs[7:2]: begin
                    rdata_d[7:0] = protect_latch_q;
                    rdata_d[8] = latch_valid_q;
                    rdata_d[9] = target_valid_q;
                    rdata_d[10] = blocked_q;
                    rdata_d[11] = elevated_pin_voltage;
                end
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign hrdata = rdata_q;
endmodule : flash_block_protect_gate

// ### verification/flash_gate_chk.sv
// Purpose: port checker for the protection gate
// Assumes: register window at offset zero
// Notes: bound to every gate instance
`timescale 1ns/100ps
module flash_gate_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic [7:0] flash_block_protect_byte,
    input wire logic elevated_pin_voltage,
    input wire logic high_voltage_enable,
    input wire logic program_select,
    input wire logic erase_select,
    input wire logic [15:0] target_addr,
    input wire logic protect_blocked
);
    logic rd_pb, wr_tg;
    assign rd_pb = hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h08;
    assign wr_tg = hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h10;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_high_voltage_enable_needs_sel: assert property (
        high_voltage_enable |-> program_select || erase_select) else $error("high_voltage_enable alone");
    a_sel_interlock: assert property (
        !(program_select && erase_select)) else $error("both selects");
    a_block_drops: assert property (
        $rose(protect_blocked) |-> !program_select && !erase_select && !high_voltage_enable)
        else $error("block left select");
    a_bypass_clean: assert property (
        $rose(protect_blocked) |-> !$past(elevated_pin_voltage)) else $error("bypass blocked");
    a_open_clean: assert property (
        $rose(protect_blocked) && $past(flash_block_protect_byte) == 8'h00
        |-> $past(target_addr[15:11]) == 5'h1f) else $error("open byte blocked");
    a_high_voltage_enable_from_data: assert property (
        $rose(high_voltage_enable) |-> $past(hwdata[3])) else $error("high_voltage_enable cause");
    a_latch_read: assert property (
        rd_pb |=> hrdata[7:0] == $past(flash_block_protect_byte)) else $error("protect read");
    a_target_take: assert property (
        wr_tg && (program_select || erase_select) |=> ##1 target_addr == $past(hwdata[15:0]))
        else $error("target capture");
endmodule : flash_gate_chk
bind flash_block_protect_gate flash_gate_chk i_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .flash_block_protect_byte(flash_block_protect_byte),
    .elevated_pin_voltage(elevated_pin_voltage), .high_voltage_enable(high_voltage_enable),
    .program_select(program_select), .erase_select(erase_select),
    .target_addr(target_addr), .protect_blocked(protect_blocked));

// ### verification/cpu_bus_master.sv
// Purpose: cpu side model issuing single word bus transfers
// Assumes: hready sampled at rising edges
// Notes: wait loops unbounded, bench watchdog covers them
`timescale 1ns/100ps
module cpu_bus_master (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        hwdata <= ~hwdata;
        do @(posedge hclk); while (!hready);
        htrans <= 2'b00;
        if (w) hwdata <= d;
        do @(posedge hclk); while (!hready);
        r = hrdata;
    endtask : xfer
    // select, arm latch, then name the target
    task op(input logic [31:0] ctrl, input logic [31:0] tgt, output logic [31:0] pb);
        logic [31:0] x;
        xfer(1'b1, flash_protect_pkg::ctrl_ofs, ctrl, x);
        xfer(1'b0, flash_protect_pkg::protect_byte_ofs, 32'h0, pb);
        xfer(1'b1, flash_protect_pkg::flash_write_ofs, tgt, x);
    endtask : op
endmodule : cpu_bus_master

// ### verification/flash_block_protect_gate_tb.sv
// Purpose: self-checking bench for the protection gate
// Assumes: zero wait slave, fixed seed
// Notes: expected block decision worked out locally
`timescale 1ns/100ps
module flash_block_protect_gate_tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, elev, hve, psel, esel, blk;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] pb_q;
    logic [15:0] tgt;
    int fail_count = 0, samples_checked = 0, seed = 32'h2f14, r;
    flash_block_protect_gate i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flash_block_protect_byte(pb_q),
        .elevated_pin_voltage(elev), .high_voltage_enable(hve), .program_select(psel),
        .erase_select(esel), .target_addr(tgt), .protect_blocked(blk));
    cpu_bus_master i_cpu (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic logic hit(logic [7:0] p, logic er, logic [1:0] bs, logic [15:0] t);
        logic [15:0] m, st;
        m = !er ? 16'hffff : bs == 2'b00 ? 16'hf800 : bs == 2'b01 ? 16'hfc00 :
            bs == 2'b10 ? 16'hffc0 : 16'hfff8;
        st = p[0] ? 16'h7800 : p[1] ? 16'h7880 : p[2] ? 16'h7900 : 16'h7a00;
        return (p[3:0] != 4'h0 && (((t & m) <= 16'h7fef && (t | ~m) >= st) ||
            (t | ~m) >= 16'hfff0)) || ((t & m) <= 16'hfff0 && (t | ~m) >= 16'hfff0);
    endfunction : hit
    task run(input logic [7:0] p, input logic er, input logic [1:0] bs, input logic [15:0] t,
        input logic hv);
        logic b;
        logic [31:0] c;
        b = hit(p, er, bs, t) && !hv;
        c = {26'h0, bs, 2'b00, er, ~er};
        pb_q <= p;
        elev <= hv;
        @(posedge hclk);
        i_cpu.op(c, {16'h0, t}, rd);
        check("protect read", rd[7:0], p);
        repeat (2) @(posedge hclk);
        #1;
        check("program select", psel, !er && !b);
        check("erase select", esel, er && !b);
        check("blocked flag", blk, b);
        i_cpu.xfer(1'b0, flash_protect_pkg::target_ofs, 32'h0, rd);
        check("target", rd[15:0], t);
        check("target port", tgt, t);
        i_cpu.xfer(1'b0, flash_protect_pkg::status_ofs, 32'h0, rd);
        check("status", rd[11:0], {hv, b, !b, 1'b1, p});
        i_cpu.xfer(1'b1, flash_protect_pkg::ctrl_ofs, c | 32'h8, rd);
        #1;
        check("high voltage", hve, !b);
        i_cpu.xfer(1'b1, flash_protect_pkg::ctrl_ofs, 32'h0, rd);
    endtask : run
    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        #400000;
        fail_count++;
        wrap_up();
    end
    initial begin
        hresetn = 1'b0;
        pb_q = 8'h00;
        elev = 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        check("reset state", {hreadyout, hresp, hve, psel, esel, blk, tgt}, {1'b1, 21'h0});
        run(8'h08, 1'b0, 2'b00, 16'h79ff, 1'b0);
        run(8'h08, 1'b0, 2'b00, 16'h7a00, 1'b0);
        run(8'h02, 1'b0, 2'b00, 16'h787f, 1'b0);
        run(8'h04, 1'b0, 2'b00, 16'h7900, 1'b0);
        run(8'h01, 1'b0, 2'b00, 16'h7800, 1'b0);
        run(8'h06, 1'b0, 2'b00, 16'h7880, 1'b0);
        run(8'h00, 1'b1, 2'b00, 16'h7a00, 1'b0);
        run(8'h00, 1'b0, 2'b00, 16'hfff0, 1'b0);
        run(8'h00, 1'b1, 2'b11, 16'hfff0, 1'b1);
        run(8'h08, 1'b1, 2'b00, 16'hfff4, 1'b0);
        run(8'h08, 1'b1, 2'b01, 16'h7800, 1'b0);
        run(8'h08, 1'b1, 2'b10, 16'h79c0, 1'b0);
        run(8'h08, 1'b1, 2'b11, 16'h79f8, 1'b0);
        run(8'h0f, 1'b1, 2'b00, 16'hfff0, 1'b1);
        $display("corner cases done");
        repeat (40) begin
            r = $random(seed);
            run(r[3:0] & r[7:4], r[8], r[10:9], r[11] ? 16'h7800 + r[31:16] % 16'h7f0 :
                16'hfff0 | r[15:12], r[14:12] == 3'h0);
        end
        i_cpu.xfer(1'b0, 8'h14, 32'h0, rd);
        check("unmapped read", rd, 32'h0);
        i_cpu.xfer(1'b1, flash_protect_pkg::ctrl_ofs, 32'h1, rd);
        i_cpu.xfer(1'b1, flash_protect_pkg::flash_write_ofs, 32'h7800, rd);
        i_cpu.xfer(1'b1, flash_protect_pkg::ctrl_ofs, 32'h9, rd);
        #1;
        check("unarmed high voltage", hve, 1'b0);
        i_cpu.xfer(1'b1, flash_protect_pkg::ctrl_ofs, 32'h3, rd);
        #1;
        check("select pair", {psel, esel}, 2'b00);
        $display("random and bus tests done");
        wrap_up();
    end
endmodule : flash_block_protect_gate_tb
